// [hdl/fwp_protect_top.sv]
`timescale 1ns/100ps
`default_nettype none
module fwp_protect_top #(
    parameter int PUW_CYC = fwp_pkg::FWP_PUW_CYCLES,
    parameter int TW_CYC = fwp_pkg::FWP_TW_CYCLES,
    parameter int BLK_BITS = fwp_pkg::FWP_BLK_BITS
) (
    // Clock and power-on reset
    input wire logic ref_clk,
    input wire logic rst,
    // Serial pins
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic dio,
    input wire logic wp_n,
    output logic data_out,
    output logic data_out_oe,
    // Array program and erase engine
    output logic op_start,
    output fwp_pkg::fwp_op_t op_kind,
    output logic [fwp_pkg::FWP_ADDR_W-1:0] op_addr,
    input wire logic op_done,
    // Status view
    output logic [7:0] status,
    output logic power_down
);
    import fwp_pkg::*;

    localparam int PUW_W = $clog2(PUW_CYC + 1);
    localparam int TW_W = $clog2(TW_CYC + 1);
    localparam logic [7:0] BLK_LAST = 8'((1 << BLK_BITS) - 1);

    logic cs_s, sclk_s, dio_s, wp_s;
    logic cs_d_q, sclk_d_q;
    logic sclk_rise, sclk_fall, cs_rise, cs_fall;
    logic [PUW_W-1:0] puw_cnt_q;
    logic puw_done_q;
    logic [2:0] phase_q, byte_cnt_q;
    logic [7:0] sh_q, op_q, sr_in_q;
    logic [FWP_ADDR_W-1:0] addr_q;
    logic op_valid_q, rdsr_q;
    logic [7:0] out_q;
    logic wel_q, pd_q, tb_q, srp_q;
    logic [2:0] bp_q;
    fwp_busy_t st_q;
    logic [TW_W-1:0] tw_cnt_q;
    logic [7:0] sr_word;
    logic busy, lock, ends_ok, tw_end, finish, arr_prot;
    logic go_wren, go_wrdi, go_pd, go_rpd, go_wrsr, go_arr;
    fwp_op_t arr_kind;

    fwp_sync #(
        .W(4),
        .RST_VAL(FWP_PIN_RST)
    ) u_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .din({cs_n, sclk, dio, wp_n}),
        .dout({cs_s, sclk_s, dio_s, wp_s})
    );

    // Edge detection on the synchronised pins.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cs_d_q <= 1'b1;
            sclk_d_q <= 1'b0;
        end else begin
            cs_d_q <= cs_s;
            sclk_d_q <= sclk_s;
        end
    end

    assign sclk_rise = sclk_s & ~sclk_d_q & ~cs_s;
    assign sclk_fall = ~sclk_s & sclk_d_q & ~cs_s;
    assign cs_fall = ~cs_s & cs_d_q;
    assign cs_rise = cs_s & ~cs_d_q;

    // Power-up write delay counter.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            puw_cnt_q <= '0;
            puw_done_q <= 1'b0;
        end else if (!puw_done_q) begin
            if (puw_cnt_q == PUW_W'(PUW_CYC - 1)) begin
                puw_done_q <= 1'b1;
            end else begin
                puw_cnt_q <= puw_cnt_q + 1'b1;
            end
        end
    end

    // Bit and byte counting, opcode, data byte and address capture.
    always_ff @(posedge ref_clk) begin
        if (rst || cs_fall) begin
            phase_q <= '0;
            byte_cnt_q <= '0;
            sh_q <= '0;
            op_q <= '0;
            sr_in_q <= '0;
            addr_q <= '0;
            op_valid_q <= 1'b0;
        end else if (sclk_rise) begin
            phase_q <= phase_q + 1'b1;
            sh_q <= {sh_q[6:0], dio_s};
            if (byte_cnt_q >= FWP_LEN_ONE && byte_cnt_q < FWP_LEN_ERASE) begin
                addr_q <= {addr_q[FWP_ADDR_W-2:0], dio_s};
            end
            if (phase_q == 3'h7) begin
                if (byte_cnt_q != FWP_LEN_SAT) begin
                    byte_cnt_q <= byte_cnt_q + 1'b1;
                end
                if (byte_cnt_q == 3'h0) begin
                    op_q <= {sh_q[6:0], dio_s};
                    op_valid_q <= 1'b1;
                end
                if (byte_cnt_q == FWP_LEN_ONE) begin
                    sr_in_q <= {sh_q[6:0], dio_s};
                end
            end
        end
    end

    assign busy = (st_q != FWP_ST_IDLE);
    assign lock = srp_q & ~wp_s;
    assign ends_ok = cs_rise & op_valid_q & (phase_q == 3'h0);
    assign tw_end = (st_q == FWP_ST_SRW) && (tw_cnt_q == TW_W'(TW_CYC - 1));
    assign finish = ((st_q == FWP_ST_ARRAY) && op_done) || tw_end;
    assign arr_prot = fwp_blk_prot(bp_q, tb_q, addr_q[FWP_ADDR_W-1:16], BLK_LAST);

    // Instruction acceptance at the rising edge of chip select.
    always_comb begin
        go_wren = 1'b0;
        go_wrdi = 1'b0;
        go_pd = 1'b0;
        go_rpd = 1'b0;
        go_wrsr = 1'b0;
        go_arr = 1'b0;
        arr_kind = FWP_KIND_NONE;
        if (ends_ok && pd_q) begin
            go_rpd = (op_q == FWP_OP_RPD);
        end else if (ends_ok && !busy) begin
            unique case (op_q)
                FWP_OP_WREN: go_wren = puw_done_q && (byte_cnt_q == FWP_LEN_ONE);
                FWP_OP_WRDI: go_wrdi = (byte_cnt_q == FWP_LEN_ONE);
                FWP_OP_PD: go_pd = (byte_cnt_q == FWP_LEN_ONE);
                FWP_OP_WRSR: begin
                    go_wrsr = puw_done_q && wel_q && !lock
                        && (byte_cnt_q == FWP_LEN_WRSR);
                end
                FWP_OP_PP: begin
                    arr_kind = FWP_KIND_PP;
                    go_arr = (byte_cnt_q >= FWP_LEN_PP_MIN) && !arr_prot;
                end
                FWP_OP_SE: begin
                    arr_kind = FWP_KIND_SE;
                    go_arr = (byte_cnt_q == FWP_LEN_ERASE) && !arr_prot;
                end
                FWP_OP_BE: begin
                    arr_kind = FWP_KIND_BE;
                    go_arr = (byte_cnt_q == FWP_LEN_ERASE) && !arr_prot;
                end
                FWP_OP_CE: begin
                    arr_kind = FWP_KIND_CE;
                    go_arr = (byte_cnt_q == FWP_LEN_ONE) && (bp_q == FWP_BP_NONE);
                end
                default: arr_kind = FWP_KIND_NONE;
            endcase
            go_arr = go_arr && puw_done_q && wel_q;
        end
    end

    // Write enable latch.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wel_q <= FWP_WEL_RST;
        end else if (go_wren) begin
            wel_q <= 1'b1;
        end else if (go_wrdi || finish) begin
            wel_q <= 1'b0;
        end
    end

    // Power-down state.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pd_q <= 1'b0;
        end else if (go_pd) begin
            pd_q <= 1'b1;
        end else if (go_rpd) begin
            pd_q <= 1'b0;
        end
    end

    // Busy state machine and status write timer.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_q <= FWP_ST_IDLE;
            tw_cnt_q <= '0;
        end else begin
            unique case (st_q)
                FWP_ST_IDLE: begin
                    tw_cnt_q <= '0;
                    if (go_arr) begin
                        st_q <= FWP_ST_ARRAY;
                    end else if (go_wrsr) begin
                        st_q <= FWP_ST_SRW;
                    end
                end
                FWP_ST_ARRAY: begin
                    if (op_done) begin
                        st_q <= FWP_ST_IDLE;
                    end
                end
                FWP_ST_SRW: begin
                    tw_cnt_q <= tw_cnt_q + 1'b1;
                    if (tw_end) begin
                        st_q <= FWP_ST_IDLE;
                    end
                end
                default: st_q <= FWP_ST_IDLE;
            endcase
        end
    end

    // Non-volatile fields, committed when the status write ends.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            bp_q <= FWP_BP_RST;
            tb_q <= FWP_TB_RST;
            srp_q <= FWP_SRP_RST;
        end else if (tw_end && !lock) begin
            bp_q <= sr_in_q[FWP_SR_BP_LSB+2:FWP_SR_BP_LSB];
            tb_q <= sr_in_q[FWP_SR_TB];
            srp_q <= sr_in_q[FWP_SR_SRP];
        end
    end

    // Status word assembly.
    always_comb begin
        sr_word = '0;
        sr_word[FWP_SR_BUSY] = busy;
        sr_word[FWP_SR_WEL] = wel_q;
        sr_word[FWP_SR_BP_LSB+2:FWP_SR_BP_LSB] = bp_q;
        sr_word[FWP_SR_TB] = tb_q;
        sr_word[FWP_SR_RSV] = 1'b0;
        sr_word[FWP_SR_SRP] = srp_q;
    end

    // Status read: reload each byte, shift out on falling clock edges.
    always_ff @(posedge ref_clk) begin
        if (rst || cs_fall) begin
            rdsr_q <= 1'b0;
            out_q <= '0;
            data_out <= 1'b0;
        end else if (sclk_rise && phase_q == 3'h7) begin
            if (byte_cnt_q == 3'h0) begin
                rdsr_q <= ({sh_q[6:0], dio_s} == FWP_OP_RDSR) && !pd_q;
            end
            out_q <= sr_word;
        end else if (sclk_fall && rdsr_q) begin
            data_out <= out_q[7];
            out_q <= {out_q[6:0], 1'b0};
        end
    end

    assign data_out_oe = rdsr_q & ~cs_s;

    // Engine request and status outputs.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            op_start <= 1'b0;
            op_kind <= FWP_KIND_NONE;
            op_addr <= '0;
            status <= '0;
        end else begin
            op_start <= go_arr;
            if (go_arr) begin
                op_kind <= arr_kind;
                op_addr <= addr_q;
            end
            status <= sr_word;
        end
    end

    assign power_down = pd_q;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_wrsr_go;
        go_wrsr;
    endsequence

    sequence s_sr_busy;
        busy[*8];
    endsequence

    sequence s_arr_done;
        (st_q == FWP_ST_ARRAY) && op_done;
    endsequence

    reset_quiet_a: assert property ($past(rst) |-> !wel_q && !busy && !pd_q && !op_start)
        else $error("state not cleared after reset");
    delay_no_wel_a: assert property (!puw_done_q |-> !wel_q && !busy)
        else $error("write enabled before power-up delay");
    arr_done_a: assert property (s_arr_done |=> !busy && !wel_q)
        else $error("busy or latch kept after array completion");
    wrsr_busy_a: assert property (s_wrsr_go |=> s_sr_busy)
        else $error("status write did not hold busy");
    busy_ignore_a: assert property ($past(busy) |-> !op_start && !$rose(wel_q))
        else $error("instruction obeyed while busy");
    pd_ignore_a: assert property (pd_q && $past(pd_q) |-> $stable(wel_q) && !op_start)
        else $error("instruction obeyed in power-down");
    lock_hold_a: assert property (lock && $past(lock) |-> $stable({bp_q, tb_q}))
        else $error("protect bits changed while locked");
    prot_reject_a: assert property (op_start && op_kind != FWP_KIND_CE
        |-> !fwp_blk_prot(bp_q, tb_q, op_addr[FWP_ADDR_W-1:16], BLK_LAST))
        else $error("protected block sent to engine");
    wel_needed_a: assert property (op_start |-> $past(wel_q) && $past(puw_done_q))
        else $error("array operation started without write enable");

endmodule // fwp_protect_top
`default_nettype wire

// [hdl/fwp_pkg.sv]
package fwp_pkg;

    // Instruction codes taken from the first byte after chip select falls.
    localparam logic [7:0] FWP_OP_WREN = 8'h06;
    localparam logic [7:0] FWP_OP_WRDI = 8'h04;
    localparam logic [7:0] FWP_OP_RDSR = 8'h05;
    localparam logic [7:0] FWP_OP_WRSR = 8'h01;
    localparam logic [7:0] FWP_OP_PP = 8'h02;
    localparam logic [7:0] FWP_OP_SE = 8'h20;
    localparam logic [7:0] FWP_OP_BE = 8'hd8;
    localparam logic [7:0] FWP_OP_CE = 8'hc7;
    localparam logic [7:0] FWP_OP_PD = 8'hb9;
    localparam logic [7:0] FWP_OP_RPD = 8'hab;

    // Whole bytes an instruction must carry before chip select rises; FWP_LEN_SAT is where the byte count stops.
    localparam logic [2:0] FWP_LEN_ONE = 3'h1;
    localparam logic [2:0] FWP_LEN_WRSR = 3'h2;
    localparam logic [2:0] FWP_LEN_ERASE = 3'h4;
    localparam logic [2:0] FWP_LEN_PP_MIN = 3'h5;
    localparam logic [2:0] FWP_LEN_SAT = 3'h7;

    // Status register field positions.
    localparam int FWP_SR_BUSY = 0;
    localparam int FWP_SR_WEL = 1;
    localparam int FWP_SR_BP_LSB = 2;
    localparam int FWP_SR_TB = 5;
    localparam int FWP_SR_RSV = 6;
    localparam int FWP_SR_SRP = 7;

    // Factory values of the non-volatile fields and of the latch.
    localparam logic [2:0] FWP_BP_RST = 3'h0;
    localparam logic FWP_TB_RST = 1'b0;
    localparam logic FWP_SRP_RST = 1'b0;
    localparam logic FWP_WEL_RST = 1'b0;

    // Protect field codes with a fixed meaning.
    localparam logic [2:0] FWP_BP_NONE = 3'h0;
    localparam logic [2:0] FWP_BP_ALL = 3'h7;

    // Timing.
    localparam int FWP_CLK_PERIOD_NS = 50;
    localparam int FWP_PUW_TIME_US = 10;
    localparam int FWP_PUW_CYCLES = (FWP_PUW_TIME_US * 1000 + FWP_CLK_PERIOD_NS - 1)
        / FWP_CLK_PERIOD_NS;
    localparam int FWP_TW_TIME_US = 15;
    localparam int FWP_TW_CYCLES = (FWP_TW_TIME_US * 1000 + FWP_CLK_PERIOD_NS - 1)
        / FWP_CLK_PERIOD_NS;

    // Array geometry: log2 of the number of 64 KB blocks.
    localparam int FWP_BLK_BITS = 7;
    localparam int FWP_ADDR_W = 24;

    // Pin synchroniser reset value, order cs_n, sclk, dio, wp_n.
    localparam logic [3:0] FWP_PIN_RST = 4'h9;

    typedef enum logic [2:0] {
        FWP_KIND_NONE = 3'b000,
        FWP_KIND_PP = 3'b001,
        FWP_KIND_SE = 3'b010,
        FWP_KIND_BE = 3'b011,
        FWP_KIND_CE = 3'b100
    } fwp_op_t;

    typedef enum logic [1:0] {
        FWP_ST_IDLE = 2'b00,
        FWP_ST_ARRAY = 2'b01,
        FWP_ST_SRW = 2'b10
    } fwp_busy_t;

    // True when a 64 KB block lies in the range picked by the protect field and side.
    function automatic logic fwp_blk_prot(input logic [2:0] bp, input logic tb,
                                          input logic [7:0] blk, input logic [7:0] last);
        logic [8:0] nblk;
        logic [8:0] cnt;
        logic hit;
        nblk = {1'b0, last} + 9'h001;
        cnt = nblk >> (3'h7 - bp);
        if (bp == FWP_BP_NONE) begin
            hit = 1'b0;
        end else if (bp == FWP_BP_ALL) begin
            hit = 1'b1;
        end else if (tb) begin
            hit = {1'b0, blk} < cnt;
        end else begin
            hit = {1'b0, blk} >= (nblk - cnt);
        end
        return hit;
    endfunction

endpackage

// [hdl/fwp_sync.sv]
`timescale 1ns/100ps
`default_nettype none
module fwp_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Asynchronous inputs and their synchronised copies
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);

    logic [W-1:0] meta_q;

    // Two flip-flops; only the second stage reads the first.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            meta_q <= RST_VAL;
            dout <= RST_VAL;
        end else begin
            meta_q <= din;
            dout <= meta_q;
        end
    end

endmodule // fwp_sync
`default_nettype wire

// [test/fwp_spi_host.sv]
`timescale 1ns/100ps
`default_nettype none
module fwp_spi_host (
    // Clock
    input wire logic ref_clk,
    // Serial pins
    output logic cs_n,
    output logic sclk,
    output logic dio,
    input wire logic data_out
);
    logic [7:0] rx;

    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        dio = 1'b0;
        rx = 8'h00;
    end

    // Sends the top nbits of frame MSB first in mode 0 and keeps the last eight bits read.
    // The clock only runs inside a frame, and the data line flips once the frame ends.
    task automatic xfer(input logic [39:0] frame, input int nbits);
        int i;
        cs_n <= 1'b0;
        repeat (3) @(posedge ref_clk);
        for (i = 0; i < nbits; i++) begin
            dio <= frame[39-i];
            repeat (5) @(posedge ref_clk);
            rx <= {rx[6:0], data_out};
            sclk <= 1'b1;
            repeat (3) @(posedge ref_clk);
            sclk <= 1'b0;
        end
        repeat (3) @(posedge ref_clk);
        cs_n <= 1'b1;
        dio <= ~dio;
        repeat (8) @(posedge ref_clk);
    endtask
endmodule // fwp_spi_host
`default_nettype wire

// [test/fwp_protect_top_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module fwp_protect_top_tb;
    import fwp_pkg::*;
    localparam int PUW = 300;
    localparam int TW = 10;
    logic ref_clk, rst, wp_n, op_done;
    logic cs_n, sclk, dio, data_out, data_out_oe, op_start, power_down;
    fwp_op_t op_kind;
    logic [23:0] op_addr;
    logic [7:0] status, v;
    logic host_din;
    int n_mismatch = 0;
    int comparisons = 0;
    int starts = 0;
    logic [7:0] t_sr [7] = '{8'h04, 8'h04, 8'h24, 8'h24, 8'h1c, 8'h18, 8'h00};
    logic [7:0] t_op [7] = '{FWP_OP_SE, FWP_OP_SE, FWP_OP_BE, FWP_OP_BE, FWP_OP_SE,
                             FWP_OP_SE, FWP_OP_CE};
    logic [23:0] t_ad [7] = '{24'h7e0000, 24'h7d0000, 24'h010000, 24'h020000, 24'h000000,
                              24'h3f0000, 24'h000000};
    logic [2:0] t_kd [7] = '{3'h0, 3'h2, 3'h0, 3'h3, 3'h0, 3'h2, 3'h4};

    // A released output line shows the inverse of its last value to the host.
    assign host_din = data_out_oe ? data_out : ~data_out;

    fwp_spi_host host_u (.ref_clk(ref_clk), .cs_n(cs_n), .sclk(sclk), .dio(dio),
        .data_out(host_din));

    fwp_protect_top #(.PUW_CYC(PUW), .TW_CYC(TW), .BLK_BITS(7)) dut_u (
        .ref_clk(ref_clk), .rst(rst), .cs_n(cs_n), .sclk(sclk), .dio(dio), .wp_n(wp_n),
        .data_out(data_out), .data_out_oe(data_out_oe), .op_start(op_start),
        .op_kind(op_kind), .op_addr(op_addr), .op_done(op_done), .status(status),
        .power_down(power_down));

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        if (op_start === 1'b1) begin
            starts++;
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic op1(input logic [7:0] op);
        host_u.xfer({op, 32'h0}, 8);
    endtask

    task automatic sr_read(output logic [7:0] r);
        host_u.xfer({FWP_OP_RDSR, 32'h0}, 16);
        r = host_u.rx;
    endtask

    task automatic wait_idle;
        int i;
        for (i = 0; i < 2000 && status[FWP_SR_BUSY] !== 1'b0; i++) begin
            @(posedge ref_clk);
        end
        if (i == 2000) begin
            n_mismatch++;
            conclude();
        end
    endtask

    task automatic sr_write(input logic [7:0] val);
        op1(FWP_OP_WREN);
        host_u.xfer({FWP_OP_WRSR, val, 24'h0}, 16);
        wait_idle();
        repeat (2) @(posedge ref_clk);
    endtask

    task automatic finish_op;
        op_done <= 1'b1;
        @(posedge ref_clk);
        op_done <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask

    initial begin
        int k;
        int n;
        rst = 1'b1;
        wp_n = 1'b1;
        op_done = 1'b0;
        repeat (2) @(posedge ref_clk);
        check("status in reset", status, 8'h00);
        check("pd in reset", power_down, 1'b0);
        rst <= 1'b0;
        op1(FWP_OP_WREN);
        check("early wren", status, 8'h00);
        repeat (PUW) @(posedge ref_clk);
        sr_read(v);
        check("status after boot", v, 8'h00);
        check("oe released", data_out_oe, 1'b0);
        op1(FWP_OP_WREN);
        sr_read(v);
        check("wel set", v, 8'h02);
        op1(FWP_OP_WRDI);
        check("wel cleared", status, 8'h00);
        host_u.xfer({FWP_OP_PP, 24'h000100, 8'ha5}, 40);
        check("pp without wel", starts, 0);
        op1(FWP_OP_WREN);
        host_u.xfer({FWP_OP_PP, 24'h120304, 8'h5a}, 40);
        check("pp start", starts, 1);
        check("pp kind", op_kind, FWP_KIND_PP);
        check("pp addr", op_addr, 24'h120304);
        check("busy", status, 8'h03);
        op1(FWP_OP_WRDI);
        sr_read(v);
        check("busy ignores", v, 8'h03);
        finish_op();
        check("done", status, 8'h00);
        for (k = 0; k < 7; k++) begin
            sr_write(t_sr[k]);
            check("sr written", status, t_sr[k]);
            n = starts;
            op1(FWP_OP_WREN);
            host_u.xfer({t_op[k], t_ad[k], 8'h0}, (t_op[k] == FWP_OP_CE) ? 8 : 32);
            check("erase gate", starts - n, (t_kd[k] != 3'h0) ? 1 : 0);
            if (t_kd[k] != 3'h0) begin
                check("erase kind", op_kind, t_kd[k]);
                finish_op();
                check("erase done", status, t_sr[k]);
            end else begin
                op1(FWP_OP_WRDI);
            end
        end
        sr_write(8'h80);
        wp_n <= 1'b0;
        sr_write(8'h9c);
        sr_read(v);
        check("locked", v & 8'hfd, 8'h80);
        wp_n <= 1'b1;
        sr_write(8'hdc);
        check("unlocked", status, 8'h9c);
        op1(FWP_OP_PD);
        check("pd on", power_down, 1'b1);
        op1(FWP_OP_WREN);
        check("pd ignores", status, 8'h9c);
        op1(FWP_OP_RPD);
        check("pd off", power_down, 1'b0);
        conclude();
    end
endmodule // fwp_protect_top_tb
`default_nettype wire
